// ### pkg/bsi_pkg.sv
// Constants for the bus slave, interrupt and DMA request interface.
// Assumes a 20 MHz system clock and bus inputs already at logic level.
package bsi_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned GRANT_DELAY_NS = 100;
  localparam int unsigned GRANT_DELAY_CYC =
    (GRANT_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] GRANT_DELAY_CNT = 4'(GRANT_DELAY_CYC);
  localparam int unsigned CSR_EN_A_BIT = 6;
  localparam int unsigned CSR_EN_B_BIT = 14;
  localparam int unsigned CSR_REQ_A_BIT = 7;
  localparam int unsigned CSR_REQ_B_BIT = 15;
  localparam logic [1:0] REG_CSR = 2'h0;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

// ### verilog/bsi_slave.sv
// Device-side register strobes, dual interrupt and DMA request logic.
// Assumes bus inputs are true-high levels synchronous to clk_sys.
`timescale 1ns/10ps
module bsi_slave
  import bsi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Stored address and write control
  input wire logic stored_addr_bit_zero,
  input wire logic stored_addr_bit_one,
  input wire logic stored_addr_bit_two,
  input wire logic byte_write_indicator,
  input wire logic write_data_en,
  input wire logic [15:0] write_data,
  // Bus control inputs, active high
  input wire logic bus_init,
  input wire logic bus_data_in_strobe,
  input wire logic irq_ack_chain_in,
  input wire logic dma_grant_chain_in,
  input wire logic bus_sync,
  input wire logic bus_reply_in,
  // User sources
  input wire logic source_a_service_request,
  input wire logic source_b_service_request,
  input wire logic dma_req,
  input wire logic [15:0] vector_addr,
  // Register file
  output logic [15:0] reg0,
  output logic [15:0] reg1,
  output logic [15:0] reg2,
  output logic [15:0] reg3,
  output logic [15:0] read_data,
  // Bus outputs, active high
  output logic bus_irq_line,
  output logic irq_ack_chain_out,
  output logic bus_reply,
  output logic vector_en,
  output logic bus_dma_request,
  output logic dma_grant_chain_out,
  output logic selection_acknowledge,
  output logic master
);
  logic [1:0] s_init, s_din, s_iak, s_grant, s_sync, s_rply;
  logic din_q, iak_q, grant_q;
  logic en_a, en_b, pend_a, pend_b, ack_a, ack_b;
  logic req_a_q, req_b_q, claim, cycle_done;
  logic [3:0] dly_cnt;
  wire init = s_init[1];
  wire din_rise = s_din[1] & ~din_q;
  wire iak_rise = s_iak[1] & ~iak_q;
  wire grant = s_grant[1];
  wire req_a = source_a_service_request & en_a;
  wire req_b = source_b_service_request & en_b;
  wire irq_a = pend_a & req_a;
  wire irq_b = pend_b & req_b;
  wire delayed_grant = grant & (dly_cnt == GRANT_DELAY_CNT);
  wire grant_forward_enable = delayed_grant & ~claim & ~dma_req;
  wire [1:0] reg_sel = {stored_addr_bit_two, stored_addr_bit_one};
  wire lo_wr = write_data_en & (~byte_write_indicator
    | ~stored_addr_bit_zero);
  wire hi_wr = write_data_en & (~byte_write_indicator
    | stored_addr_bit_zero);
  wire [15:0] mux_data = reg_sel == 2'h0 ? reg0 :
    reg_sel == 2'h1 ? reg1 : reg_sel == 2'h2 ? reg2 : reg3;
  wire [15:0] csr_view = {irq_b, en_b, 6'h00, irq_a, en_a, reg0[5:0]};
  wire [15:0] next_read = vector_en ? vector_addr :
    (reg_sel == REG_CSR ? csr_view : mux_data);
  wire ack_any = iak_rise & (ack_a | ack_b);

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {s_init, s_din, s_iak, s_grant, s_sync, s_rply} <= 12'h000;
      {din_q, iak_q, grant_q} <= 3'h0;
    end else begin
      s_init <= {s_init[0], bus_init};
      s_din <= {s_din[0], bus_data_in_strobe};
      s_iak <= {s_iak[0], irq_ack_chain_in};
      s_grant <= {s_grant[0], dma_grant_chain_in};
      s_sync <= {s_sync[0], bus_sync};
      s_rply <= {s_rply[0], bus_reply_in};
      din_q <= s_din[1];
      iak_q <= s_iak[1];
      grant_q <= grant;
    end
  end

  // Register writes with byte lanes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {reg0, reg1, reg2, reg3} <= {4{REG_RESET}};
    end else if (init) begin
      {reg0, reg1, reg2, reg3} <= {4{REG_RESET}};
    end else begin
      if (lo_wr && reg_sel == 2'h0) reg0[7:0] <= write_data[7:0];
      if (hi_wr && reg_sel == 2'h0) reg0[15:8] <= write_data[15:8];
      if (lo_wr && reg_sel == 2'h1) reg1[7:0] <= write_data[7:0];
      if (hi_wr && reg_sel == 2'h1) reg1[15:8] <= write_data[15:8];
      if (lo_wr && reg_sel == 2'h2) reg2[7:0] <= write_data[7:0];
      if (hi_wr && reg_sel == 2'h2) reg2[15:8] <= write_data[15:8];
      if (lo_wr && reg_sel == 2'h3) reg3[7:0] <= write_data[7:0];
      if (hi_wr && reg_sel == 2'h3) reg3[15:8] <= write_data[15:8];
    end
  end

  // Enables live in the control/status register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {en_a, en_b} <= 2'h0;
    end else if (init) begin
      {en_a, en_b} <= 2'h0;
    end else begin
      if (lo_wr && reg_sel == REG_CSR) en_a <= write_data[CSR_EN_A_BIT];
      if (hi_wr && reg_sel == REG_CSR) en_b <= write_data[CSR_EN_B_BIT];
    end
  end

  // Pending flags rearm on a fresh enabled request; set beats clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {pend_a, pend_b, req_a_q, req_b_q} <= 4'hf;
    end else begin
      req_a_q <= req_a;
      req_b_q <= req_b;
      if (init) begin
        {pend_a, pend_b} <= 2'h3;
      end else begin
        if (req_a & ~req_a_q) pend_a <= 1'b1;
        else if (iak_rise & ack_a) pend_a <= 1'b0;
        if (req_b & ~req_b_q) pend_b <= 1'b1;
        else if (iak_rise & ~ack_a & ack_b) pend_b <= 1'b0;
      end
    end
  end

  // Acknowledge capture on data-in strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {ack_a, ack_b} <= 2'h0;
    end else if (init) begin
      {ack_a, ack_b} <= 2'h0;
    end else if (din_rise) begin
      ack_a <= irq_a;
      ack_b <= irq_b;
    end
  end

  // Vector and reply stand until the acknowledge drops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vector_en <= 1'b0;
    end else if (init | ~s_iak[1]) begin
      vector_en <= 1'b0;
    end else if (ack_any) begin
      vector_en <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) read_data <= REG_RESET;
    else read_data <= next_read;
  end

  // Grant delay counter gives the claim time to settle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) dly_cnt <= 4'h0;
    else if (!grant) dly_cnt <= 4'h0;
    else if (dly_cnt != GRANT_DELAY_CNT) dly_cnt <= dly_cnt + 4'h1;
  end

  // Claim and mastership
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {claim, master, cycle_done} <= 3'h0;
    end else if (init | ~dma_req) begin
      {claim, master, cycle_done} <= 3'h0;
    end else begin
      if (grant & ~grant_q & ~cycle_done) claim <= 1'b1;
      if (claim & delayed_grant & ~s_sync[1] & ~s_rply[1] & ~master)
        master <= 1'b1;
      if (master & s_rply[1]) cycle_done <= 1'b1;
    end
  end

  assign bus_irq_line = irq_a | irq_b;
  assign irq_ack_chain_out = s_iak[1] & ~ack_a & ~ack_b;
  assign bus_reply = vector_en;
  assign bus_dma_request = dma_req & ~master & ~cycle_done;
  assign selection_acknowledge = master;
  assign dma_grant_chain_out = grant_forward_enable;

  chk_word_both_lanes: assert property (@(posedge clk_sys) disable iff (rst)
    write_data_en & ~byte_write_indicator |-> lo_wr & hi_wr)
    else $error("word write missing lane");
  chk_byte_one_lane: assert property (@(posedge clk_sys) disable iff (rst)
    write_data_en & byte_write_indicator |-> lo_wr ^ hi_wr)
    else $error("byte write lane count wrong");
  chk_irq_or_line: assert property (@(posedge clk_sys) disable iff (rst)
    bus_irq_line == (irq_a | irq_b))
    else $error("irq line mismatch");
  chk_ack_block_pass: assert property (@(posedge clk_sys) disable iff (rst)
    (ack_a | ack_b) |-> ~irq_ack_chain_out)
    else $error("ack passed while requesting");
  chk_vector_reply: assert property (@(posedge clk_sys) disable iff (rst)
    ack_any & ~init |=> vector_en & bus_reply)
    else $error("no vector after ack");
  chk_master_sack: assert property (@(posedge clk_sys) disable iff (rst)
    master |-> selection_acknowledge & ~bus_dma_request)
    else $error("master without sack");
  chk_drop_clears: assert property (@(posedge clk_sys) disable iff (rst)
    ~dma_req |=> ~claim & ~master)
    else $error("claim survives drop");
  chk_claim_blocks: assert property (@(posedge clk_sys) disable iff (rst)
    claim |-> ~dma_grant_chain_out)
    else $error("grant forwarded while claimed");
  chk_grant_delay: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(grant) |-> ~delayed_grant [*2])
    else $error("grant delay too short");
  chk_init_clear: assert property (@(posedge clk_sys) disable iff (rst)
    init |=> ~en_a & ~en_b & ~ack_a & ~ack_b & ~claim)
    else $error("init did not clear");
endmodule

// ### verification/bsi_host_model.sv
// Host side model: processor strobes, acknowledge and grant chains.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/10ps
module bsi_host_model (
  // Clock and bench commands
  input wire logic clk_sys,
  input wire logic cmd_iak,
  input wire logic cmd_grant,
  // Device status
  input wire logic master,
  // Bus lines, active high
  output logic bus_data_in_strobe = 1'b0,
  output logic irq_ack_chain_in = 1'b0,
  output logic dma_grant_chain_in = 1'b0,
  output logic bus_sync = 1'b0,
  output logic bus_reply_in = 1'b0
);
  logic [2:0] dly = 3'h0;
  always_ff @(posedge clk_sys) begin
    // Data-in leads the acknowledge so the device can capture first
    bus_data_in_strobe <= cmd_iak;
    dly <= cmd_iak ? ((dly == 3'h4) ? dly : dly + 3'h1) : 3'h0;
    irq_ack_chain_in <= cmd_iak && (dly == 3'h4);
    dma_grant_chain_in <= cmd_grant;
    // One slave cycle per mastership: sync, then reply held
    bus_sync <= master;
    bus_reply_in <= master && bus_sync;
  end
endmodule

// ### verification/test_bsi_slave.sv
// Self-checking bench for the slave, interrupt and DMA logic.
// Assumes the host model answers for the processor side.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_bsi_slave;
  logic clk_sys = 0, rst = 1, bus_init = 0, write_data_en = 0;
  logic stored_addr_bit_zero = 0, stored_addr_bit_one = 0;
  logic stored_addr_bit_two = 0, byte_write_indicator = 0;
  logic [15:0] write_data = 16'h0000, vector_addr = 16'h0154;
  logic source_a_service_request = 0, source_b_service_request = 0;
  logic dma_req = 0, cmd_iak = 0, cmd_grant = 0;
  logic bus_data_in_strobe, irq_ack_chain_in, dma_grant_chain_in;
  logic bus_sync, bus_reply_in, bus_irq_line, irq_ack_chain_out;
  logic bus_reply, vector_en, bus_dma_request, dma_grant_chain_out;
  logic selection_acknowledge, master;
  logic [15:0] reg0, reg1, reg2, reg3, read_data;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  bsi_slave dut (.clk_sys, .rst, .stored_addr_bit_zero, .stored_addr_bit_one,
    .stored_addr_bit_two, .byte_write_indicator, .write_data_en, .write_data,
    .bus_init, .bus_data_in_strobe, .irq_ack_chain_in, .dma_grant_chain_in,
    .bus_sync, .bus_reply_in, .source_a_service_request,
    .source_b_service_request, .dma_req, .vector_addr, .reg0, .reg1, .reg2,
    .reg3, .read_data, .bus_irq_line, .irq_ack_chain_out, .bus_reply,
    .vector_en, .bus_dma_request, .dma_grant_chain_out,
    .selection_acknowledge, .master);
  bsi_host_model host (.clk_sys, .cmd_iak, .cmd_grant, .master,
    .bus_data_in_strobe, .irq_ack_chain_in, .dma_grant_chain_in, .bus_sync,
    .bus_reply_in);
  initial forever #25 clk_sys = ~clk_sys;
  // Generous ceiling; the full run needs about a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic waitfor(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task wr(input logic [2:0] a, input logic bw, input logic [15:0] d);
    @(posedge clk_sys);
    {stored_addr_bit_two, stored_addr_bit_one, stored_addr_bit_zero} <= a;
    byte_write_indicator <= bw;
    write_data <= d;
    write_data_en <= 1'b1;
    @(posedge clk_sys);
    write_data_en <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    {stored_addr_bit_two, stored_addr_bit_one} <= a;
    @(posedge clk_sys);
    #1;
    `CHK("read_data", e, read_data)
  endtask
  task test_regs;
    wr(3'b010, 1'b0, 16'h1234);
    wr(3'b101, 1'b1, 16'hab11);
    wr(3'b100, 1'b1, 16'h22ee);
    wr(3'b111, 1'b0, 16'h5a5a);
    rd(2'd1, 16'h1234);
    rd(2'd2, 16'habee);
    rd(2'd3, 16'h5a5a);
  endtask
  task test_irq;
    wr(3'b000, 1'b0, 16'h4040);
    source_a_service_request <= 1'b1;
    source_b_service_request <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("bus_irq_line", 1'b1, bus_irq_line)
    rd(2'd0, 16'hc0c0);
    cmd_iak <= 1'b1;
    waitfor(vector_en, 1'b1, 20);
    `CHK("vector_en", 1'b1, vector_en)
    `CHK("bus_reply", 1'b1, bus_reply)
    `CHK("irq_ack_chain_out", 1'b0, irq_ack_chain_out)
    @(posedge clk_sys);
    #1;
    `CHK("vector read", vector_addr, read_data)
    cmd_iak <= 1'b0;
    waitfor(vector_en, 1'b0, 10);
    rd(2'd0, 16'hc040);
    cmd_iak <= 1'b1;
    waitfor(vector_en, 1'b1, 20);
    cmd_iak <= 1'b0;
    waitfor(vector_en, 1'b0, 10);
    `CHK("bus_irq_line", 1'b0, bus_irq_line)
    source_a_service_request <= 1'b0;
    source_b_service_request <= 1'b0;
    cmd_iak <= 1'b1;
    waitfor(irq_ack_chain_out, 1'b1, 20);
    `CHK("irq_ack_chain_out", 1'b1, irq_ack_chain_out)
    `CHK("vector_en", 1'b0, vector_en)
    cmd_iak <= 1'b0;
  endtask
  task test_dma;
    dma_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("bus_dma_request", 1'b1, bus_dma_request)
    cmd_grant <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    `CHK("early master", 1'b0, master)
    waitfor(master, 1'b1, 20);
    `CHK("master", 1'b1, master)
    `CHK("selection_acknowledge", 1'b1, selection_acknowledge)
    `CHK("dma_grant_chain_out", 1'b0, dma_grant_chain_out)
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("bus_dma_request", 1'b0, bus_dma_request)
    dma_req <= 1'b0;
    waitfor(master, 1'b0, 8);
    `CHK("master", 1'b0, master)
    `CHK("selection_acknowledge", 1'b0, selection_acknowledge)
    waitfor(dma_grant_chain_out, 1'b1, 8);
    `CHK("dma_grant_chain_out", 1'b1, dma_grant_chain_out)
    cmd_grant <= 1'b0;
  endtask
  task test_init;
    wr(3'b000, 1'b0, 16'h4040);
    bus_init <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus_init <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(2'd0, 16'h0000);
  endtask
  task tally_and_finish;
    $display("Mismatches %0d in %0d checks", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_irq();
    test_dma();
    test_init();
    tally_and_finish();
  end
endmodule
